// ### core/pcec_top.sv
// pci command error controls with avalon-mm register slave
`timescale 1ns/1ps
`default_nettype none
`include "pcec_defs.svh"
module pcec_top
(
    input wire logic REF_CLK_I,
    input wire logic RESET_I,
    input wire logic [3:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    input wire logic ADDR_PERR_I,
    input wire logic DATA_PERR_I,
    input wire logic HOST_SERR_I,
    output logic PERR_O,
    output logic SERR_O,
    output logic FBB_OK_O,
    output logic IRQ_O
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [15:0] cmd;
        logic [2:0] mask;
        logic [31:0] rdata;
        logic ack;
        logic perr;
        logic serr;
        logic fbb;
        logic irq;
    } pcec_state_t;

    pcec_state_t st_r;
    pcec_state_t st_nxt;
    pcec_pkg::pcec_err_t err;
    pcec_pkg::pcec_pins_t pins;
    logic [2:0] stat;
    logic [2:0] ev_set;
    logic [2:0] ev_clr;
    logic wr_cmd;
    logic wr_stat;
    logic wr_mask;

    function automatic logic [15:0] pcec_lo16(input logic [31:0] d, input logic [3:0] be, input logic [15:0] old);
        pcec_lo16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
    endfunction

    assign err.addr_perr = ADDR_PERR_I;
    assign err.data_perr = DATA_PERR_I;
    assign err.host_serr = HOST_SERR_I;

    // ************************************************************
    // response and status
    // ************************************************************
    pcec_resp u_resp
    (
        .per_en_i(st_r.cmd[`PCEC_BIT_PER]),
        .serr_en_i(st_r.cmd[`PCEC_BIT_SEE]),
        .fbb_en_i(st_r.cmd[`PCEC_BIT_FBB]),
        .err_i(err),
        .pins_o(pins)
    );

    // detected parity does not look at the response bit
    assign ev_set[`PCEC_ST_DPE] = ADDR_PERR_I | DATA_PERR_I;
    assign ev_set[`PCEC_ST_SSE] = pins.serr;
    assign ev_set[`PCEC_ST_MDPE] = pins.perr;

    // one-wait-cycle access: the write lands on the edge where waitrequest is low
    assign wr_cmd = AVS_WRITE_I & st_r.ack & (AVS_ADDRESS_I == `PCEC_OFS_CMD);
    assign wr_stat = AVS_WRITE_I & st_r.ack & (AVS_ADDRESS_I == `PCEC_OFS_STAT) & AVS_BYTEENABLE_I[0];
    assign wr_mask = AVS_WRITE_I & st_r.ack & (AVS_ADDRESS_I == `PCEC_OFS_MASK) & AVS_BYTEENABLE_I[0];
    assign ev_clr = wr_stat ? AVS_WRITEDATA_I[2:0] : 3'h0;

    pcec_irq u_irq
    (
        .clk_i(REF_CLK_I),
        .rst_i(RESET_I),
        .set_i(ev_set),
        .clr_i(ev_clr),
        .stat_o(stat)
    );

    // ************************************************************
    // register slave
    // ************************************************************
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.ack = (AVS_READ_I | AVS_WRITE_I) & ~st_r.ack;
        if (wr_cmd)
            // only the three control bits store; stepping bit and top bits stay zero
            st_nxt.cmd = pcec_lo16(AVS_WRITEDATA_I, AVS_BYTEENABLE_I, st_r.cmd) & `PCEC_CMD_WMASK;
        if (wr_mask)
            st_nxt.mask = AVS_WRITEDATA_I[2:0];
        st_nxt.rdata = 32'h0;
        if (AVS_READ_I & ~st_r.ack)
        begin
            case (AVS_ADDRESS_I)
                `PCEC_OFS_CMD: st_nxt.rdata = {16'h0, st_r.cmd};
                `PCEC_OFS_STAT: st_nxt.rdata = {29'h0, stat};
                `PCEC_OFS_MASK: st_nxt.rdata = {29'h0, st_r.mask};
                default: st_nxt.rdata = 32'h0;
            endcase
        end
        st_nxt.perr = pins.perr;
        st_nxt.serr = pins.serr;
        st_nxt.fbb = pins.fbb_ok;
        st_nxt.irq = |(stat & st_r.mask);
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (RESET_I)
        begin
            st_r <= '0;
            st_r.cmd <= `PCEC_CMD_RST;
        end
        else
            st_r <= st_nxt;
    end

    assign AVS_READDATA_O = st_r.rdata;
    assign AVS_WAITREQUEST_O = ~st_r.ack;
    assign PERR_O = st_r.perr;
    assign SERR_O = st_r.serr;
    assign FBB_OK_O = st_r.fbb;
    assign IRQ_O = st_r.irq;

    // ************************************************************
    // checks
    // ************************************************************
    a_perr_gated: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        PERR_O |-> $past(st_r.cmd[`PCEC_BIT_PER]) && $past(DATA_PERR_I)) else $error("perr without enable");
    a_perr_fires: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        (st_r.cmd[`PCEC_BIT_PER] && DATA_PERR_I) |=> PERR_O) else $error("perr missed");
    a_serr_off: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        !st_r.cmd[`PCEC_BIT_SEE] |=> !SERR_O) else $error("serr while disabled");
    a_serr_fires: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        (st_r.cmd[`PCEC_BIT_SEE] && HOST_SERR_I) |=> SERR_O) else $error("serr missed");
    a_serr_apar: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        (st_r.cmd[`PCEC_BIT_SEE] && !st_r.cmd[`PCEC_BIT_PER] && ADDR_PERR_I && !HOST_SERR_I) |=> !SERR_O)
        else $error("address parity serr without response");
    a_dpe_sets: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        (ADDR_PERR_I || DATA_PERR_I) |=> stat[`PCEC_ST_DPE]) else $error("detected parity not set");
    a_cmd_zeros: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        (st_r.cmd & ~`PCEC_CMD_WMASK) == 16'h0) else $error("reserved command bits set");
    a_fbb_follow: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        FBB_OK_O == $past(st_r.cmd[`PCEC_BIT_FBB])) else $error("fast back-to-back mismatch");
    a_reset_clear: assert property (@(posedge REF_CLK_I)
        $past(RESET_I) |-> st_r.cmd == 16'h0) else $error("command not cleared");
    a_cmd_write: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        (wr_cmd && AVS_BYTEENABLE_I[0]) |=> st_r.cmd[`PCEC_BIT_PER] == $past(AVS_WRITEDATA_I[6]))
        else $error("response bit not written");

    // ************************************************************
    // bus and output checks
    // ************************************************************
    // the slave always answers after exactly one wait cycle, so the master always sees a one-cycle stall
    a_wait_idle: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        !(AVS_READ_I || AVS_WRITE_I) |=> AVS_WAITREQUEST_O)
        else $error("waitrequest low without request");
    a_wait_one: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O) |=> !AVS_WAITREQUEST_O)
        else $error("request not answered");
    a_wait_short: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        !AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
        else $error("waitrequest low too long");
    a_rdata_idle: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        AVS_WAITREQUEST_O |-> AVS_READDATA_O == 32'h0)
        else $error("read data outside answer");
    a_step_bit: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        !AVS_READDATA_O[`PCEC_BIT_WAIT])
        else $error("stepping bit reads one");
    a_top_zero: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        AVS_READDATA_O[31:16] == 16'h0)
        else $error("upper read data not zero");
    a_perr_quiet: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        !st_r.cmd[`PCEC_BIT_PER] |=> !PERR_O)
        else $error("perr while response off");
    a_serr_apar_on: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        (st_r.cmd[`PCEC_BIT_SEE] && st_r.cmd[`PCEC_BIT_PER] && ADDR_PERR_I) |=> SERR_O)
        else $error("address parity serr missed");
    a_out_reset: assert property (@(posedge REF_CLK_I)
        $past(RESET_I) |-> (!FBB_OK_O && !PERR_O && !SERR_O && !IRQ_O))
        else $error("outputs not cleared");
    a_sse_sets: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        SERR_O |-> stat[`PCEC_ST_SSE])
        else $error("signaled serr not recorded");
    a_mdpe_sets: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        PERR_O |-> stat[`PCEC_ST_MDPE])
        else $error("reported perr not recorded");
    a_mask_write: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        wr_mask |=> st_r.mask == $past(AVS_WRITEDATA_I[2:0]))
        else $error("mask not written");
    a_irq_level: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        IRQ_O == $past(|(stat & st_r.mask)))
        else $error("interrupt level wrong");
endmodule // pcec_top
`default_nettype wire

// ### shared/pcec_defs.svh
// constants for the pci command error controls block
// ************************************************************
// Notes on behaviour
// ************************************************************
// Notes on behaviour
// - parity response control bit six, read/write
// - response off: no parity pin; system-error only on host request
// - response on: parity pin; system-error if enabled
// - detected parity flag always set on parity errors
// - bit seven reads zero, never stepping
// - system-error enable clear: never drive pin
// - system-error enable set: drive on conditions
// - fast back-to-back clear: master never chains
// - fast back-to-back set: chaining permitted
// - bits fifteen to ten read zero
`ifndef PCEC_DEFS_SVH
`define PCEC_DEFS_SVH
`define PCEC_OFS_CMD 4'h0
`define PCEC_OFS_STAT 4'h4
`define PCEC_OFS_MASK 4'h8
`define PCEC_BIT_PER 6
`define PCEC_BIT_WAIT 7
`define PCEC_BIT_SEE 8
`define PCEC_BIT_FBB 9
`define PCEC_CMD_WMASK 16'h0340
`define PCEC_CMD_RST 16'h0000
`define PCEC_ST_DPE 0
`define PCEC_ST_SSE 1
`define PCEC_ST_MDPE 2
`define PCEC_ST_RST 3'h0
`endif

// ### shared/pcec_pkg.sv
// types for the pci command error controls block
package pcec_pkg;
    typedef struct packed {
        logic addr_perr;
        logic data_perr;
        logic host_serr;
    } pcec_err_t;
    typedef struct packed {
        logic perr;
        logic serr;
        logic fbb_ok;
    } pcec_pins_t;
endpackage

// ### core/pcec_resp.sv
// parity and system-error response gating
`timescale 1ns/1ps
`default_nettype none
`include "pcec_defs.svh"
module pcec_resp
(
    input wire logic per_en_i,
    input wire logic serr_en_i,
    input wire logic fbb_en_i,
    input wire pcec_pkg::pcec_err_t err_i,
    output var pcec_pkg::pcec_pins_t pins_o
);
    always_comb
    begin
        pins_o.perr = per_en_i & err_i.data_perr;
        // address parity needs both enables; host request needs only the system-error enable
        pins_o.serr = serr_en_i & ((per_en_i & err_i.addr_perr) | err_i.host_serr);
        pins_o.fbb_ok = fbb_en_i;
    end
endmodule // pcec_resp
`default_nettype wire

// ### core/pcec_irq.sv
// sticky event status with set and clear inputs; mask and level interrupt are in pcec_top
`timescale 1ns/1ps
`default_nettype none
`include "pcec_defs.svh"
module pcec_irq
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [2:0] set_i,
    input wire logic [2:0] clr_i,
    output logic [2:0] stat_o
);
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            stat_o <= `PCEC_ST_RST;
        else
            stat_o <= (stat_o & ~clr_i) | set_i; // set beats clear
    end
endmodule // pcec_irq
`default_nettype wire

// ### dv/pcec_agent.sv
// far-side pci agent model raising parity and system-error events
`timescale 1ns/1ps
`default_nettype none
module pcec_agent
(
    input wire logic clk_i,
    input wire logic [2:0] req_i,
    output var pcec_pkg::pcec_err_t err_o
);
    // ************************************************************
    // event strobes
    // ************************************************************
    // one-cycle strobes only: a held level would look like repeated errors
    always_ff @(posedge clk_i)
    begin
        err_o <= pcec_pkg::pcec_err_t'(req_i);
    end
endmodule // pcec_agent
`default_nettype wire

// ### dv/pcec_top_bench.sv
// self-checking bench for the pci command error controls block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin mismatches++; $display("Error %0s exp %h got %h", n, e, s); end end
module pcec_top_bench;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [3:0] adr = 4'h0;
    logic rd = 1'h0;
    logic wr = 1'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic wreq, perr, serr, fbb, irq;
    logic [2:0] req = 3'h0;
    logic [3:0] be = 4'hF;
    pcec_pkg::pcec_err_t err;
    int mismatches = 0;
    int num_checks = 0;
    pcec_agent agent (.clk_i(clk), .req_i(req), .err_o(err));
    pcec_top uut (.REF_CLK_I(clk), .RESET_I(rst), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
        .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq),
        .ADDR_PERR_I(err.addr_perr), .DATA_PERR_I(err.data_perr), .HOST_SERR_I(err.host_serr),
        .PERR_O(perr), .SERR_O(serr), .FBB_OK_O(fbb), .IRQ_O(irq));
    // ************************************************************
    // avalon access and event tasks
    // ************************************************************
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wdat <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wreq !== 1'h0 && n < 20);
        q = rdat;
        rd <= 1'h0;
        wr <= 1'h0;
        if (n >= 20) mismatches++;
    endtask
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        acc(1'h1, a, d, q);
    endtask
    task automatic chk_reg(input string n, input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        acc(1'h0, a, 32'h0, q);
        `CHK(n, e, q)
    endtask
    // the agent registers the strobe, the block registers its pins: two edges of lag
    task automatic hit(input logic [2:0] k, input logic ep, input logic es);
        @(posedge clk);
        req <= k;
        @(posedge clk);
        req <= 3'h0;
        @(posedge clk);
        #1;
        `CHK("perr", ep, perr)
        `CHK("serr", es, serr)
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ************************************************************
    // clock, watchdog and tests
    // ************************************************************
    initial
    begin
        forever #25 clk = ~clk;
    end
    initial
    begin
        #200000;
        mismatches++;
        summarize;
    end
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        chk_reg("cmd", 4'h0, 32'h0);
        chk_reg("mask", 4'h8, 32'h0);
        wreg(4'h0, 32'hFFFF_FFFF);
        chk_reg("cmd", 4'h0, 32'h0000_0340);
        `CHK("fbb", 1'h1, fbb)
        wreg(4'h0, 32'h0);
        chk_reg("cmd", 4'h0, 32'h0);
        `CHK("fbb", 1'h0, fbb)
        be <= 4'h1;
        wreg(4'h0, 32'h0000_0340);
        be <= 4'hF;
        chk_reg("cmd", 4'h0, 32'h0000_0040);
        wreg(4'h0, 32'h0);
        hit(3'h6, 1'h0, 1'h0);
        chk_reg("stat", 4'h4, 32'h1);
        wreg(4'h0, 32'h0000_0040);
        hit(3'h6, 1'h1, 1'h0);
        wreg(4'h0, 32'h0000_0140);
        hit(3'h4, 1'h0, 1'h1);
        hit(3'h1, 1'h0, 1'h1);
        wreg(4'h0, 32'h0000_0100);
        hit(3'h2, 1'h0, 1'h0);
        chk_reg("stat", 4'h4, 32'h7);
        `CHK("irq", 1'h0, irq)
        wreg(4'h8, 32'h2);
        chk_reg("unmapped", 4'hC, 32'h0);
        `CHK("irq", 1'h1, irq)
        wreg(4'h4, 32'h2);
        chk_reg("stat", 4'h4, 32'h5);
        `CHK("irq", 1'h0, irq)
        summarize;
    end
endmodule // pcec_top_bench
`default_nettype wire
